// ===== mdc_pkg.sv
`default_nettype none
package mdc_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFF_CHAN_STAT = 8'h0c;
	localparam logic [7:0] OFF_COUNT0 = 8'h10;
	localparam logic [7:0] OFF_COUNT1 = 8'h14;
	localparam logic [7:0] OFF_SRC0 = 8'h18;
	localparam logic [7:0] OFF_SRC1 = 8'h1c;
	localparam logic [7:0] OFF_CUR0 = 8'h24;
	localparam logic [7:0] OFF_CUR1 = 8'h28;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_PW_LSB = 2;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_NFB_BIT = 1;
	localparam int IRQ_STALL_BIT = 2;
	localparam int IRQ_W = 3;
	localparam int STAT_BUF_LSB = 4;
	localparam int STAT_ARMED_LSB = 7;
	localparam int STAT_ACT_BIT = 9;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] RST_PW = 2'h0;
	localparam logic [2:0] RST_MASK = 3'h0;

	// ----------------------------------------
	// states
	// ----------------------------------------
	typedef enum logic [3:0] {
		MDC_IDLE = 4'h1,
		MDC_STALL = 4'h2,
		MDC_MEM_RD = 4'h4,
		MDC_MEM_WR = 4'h8
	} mdc_chan_state_t;

	typedef enum logic [2:0] {
		MDC_NO_BUF = 3'h1,
		MDC_BUF_ON = 3'h2,
		MDC_BUF_NEXT = 3'h4
	} mdc_buf_state_t;

endpackage
`default_nettype wire

// ===== mdc_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_sticky_flag (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// event and clear
	input wire logic i_set,
	input wire logic i_clr,
	// flag
	output logic o_flag
);

	typedef struct packed {
		logic flag;
	} mdc_flag_state_t;

	mdc_flag_state_t flag_reg;
	mdc_flag_state_t flag_next;

	// set wins over clear
	always_comb begin
		flag_next = flag_reg;
		flag_next.flag = (flag_reg.flag & ~i_clr) | i_set;
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg.flag;

endmodule
`default_nettype wire

// ===== mdc_channel.sv
// How it works
// - upper count half reads zero
// - count drops after each completed write
// - count write makes that descriptor next
// - next-free-buffer event when second buffer starts
// - second descriptor programmable during running transfer
// - zero count keeps channel stalled
// - source base seeds the fetch address
// - source bases at 0x18 and 0x1c
// - count write copies base into pointer
// - counts at 0x10 and 0x14, low bits
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mdc_channel #(
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// peripheral request
	input wire logic i_periph_req,
	// memory read side
	output logic o_rd_req,
	output logic [31:0] o_rd_addr,
	output logic [1:0] o_rd_size,
	input wire logic i_rd_ack,
	input wire logic [31:0] i_rd_data,
	// memory write side
	output logic o_wr_req,
	output logic [31:0] o_wr_data,
	output logic [1:0] o_wr_size,
	input wire logic i_wr_ack,
	// interrupt
	output logic o_irq
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	if (COUNT_W < 3 || COUNT_W > 31) begin : g_bad_count_w
		$error("COUNT_W must lie between 3 and 31");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic enable;
		logic start_pend;
		logic [1:0] pw;
		logic [2:0] mask;
		logic irq;
		mdc_pkg::mdc_chan_state_t chan;
		mdc_pkg::mdc_buf_state_t bufs;
		logic act;
		logic [1:0] armed;
		logic [1:0][COUNT_W-1:0] count;
		logic [1:0][31:0] src;
		logic [1:0][31:0] cur;
		logic rd_req;
		logic [31:0] rd_addr;
		logic wr_req;
		logic [31:0] wr_data;
	} mdc_state_t;

	mdc_state_t r_reg;
	mdc_state_t r_next;
	logic [mdc_pkg::IRQ_W-1:0] irq_set;
	logic [mdc_pkg::IRQ_W-1:0] irq_clr;
	logic [mdc_pkg::IRQ_W-1:0] irq_flag;
	logic setup;
	logic wr_acc;
	logic [COUNT_W-1:0] step;
	logic [COUNT_W-1:0] left_after;
	logic trigger;

	assign setup = i_psel & ~i_penable;
	assign wr_acc = i_psel & i_penable & r_reg.pready & i_pwrite;
	assign step = {{(COUNT_W-1){1'b0}}, 1'b1} << r_reg.pw;
	assign left_after = (r_reg.count[r_reg.act] > step) ? r_reg.count[r_reg.act] - step :
		'0;
	assign trigger = r_reg.start_pend | i_periph_req;

	// ----------------------------------------
	// sticky interrupt flags
	// ----------------------------------------
	for (genvar g = 0; g < mdc_pkg::IRQ_W; g++) begin : g_flag
		mdc_sticky_flag u_flag (
			.i_ref_clk(i_ref_clk),
			.i_nrst(i_nrst),
			.i_set(irq_set[g]),
			.i_clr(irq_clr[g]),
			.o_flag(irq_flag[g])
		);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		irq_set = '0;
		irq_clr = '0;
		r_next.pready = 1'b0;
		r_next.pslverr = 1'b0;

		// apb read decode in the setup cycle
		if (setup) begin
			r_next.pready = 1'b1;
			r_next.prdata = mdc_pkg::RST_WORD;
			case (i_paddr)
				mdc_pkg::OFF_CTRL: begin
					r_next.prdata[mdc_pkg::CTRL_ENABLE_BIT] = r_reg.enable;
					r_next.prdata[mdc_pkg::CTRL_START_BIT] = r_reg.start_pend;
					r_next.prdata[mdc_pkg::CTRL_PW_LSB+:2] = r_reg.pw;
				end
				mdc_pkg::OFF_IRQ_STAT: begin
					r_next.prdata[mdc_pkg::IRQ_W-1:0] = irq_flag;
				end
				mdc_pkg::OFF_IRQ_MASK: begin
					r_next.prdata[mdc_pkg::IRQ_W-1:0] = r_reg.mask;
				end
				mdc_pkg::OFF_CHAN_STAT: begin
					r_next.prdata[3:0] = r_reg.chan;
					r_next.prdata[mdc_pkg::STAT_BUF_LSB+:3] = r_reg.bufs;
					r_next.prdata[mdc_pkg::STAT_ARMED_LSB+:2] = r_reg.armed;
					r_next.prdata[mdc_pkg::STAT_ACT_BIT] = r_reg.act;
				end
				mdc_pkg::OFF_COUNT0: begin
					r_next.prdata[COUNT_W-1:0] = r_reg.count[0];
				end
				mdc_pkg::OFF_COUNT1: begin
					r_next.prdata[COUNT_W-1:0] = r_reg.count[1];
				end
				mdc_pkg::OFF_SRC0: begin
					r_next.prdata = r_reg.src[0];
				end
				mdc_pkg::OFF_SRC1: begin
					r_next.prdata = r_reg.src[1];
				end
				mdc_pkg::OFF_CUR0: begin
					r_next.prdata = r_reg.cur[0];
				end
				mdc_pkg::OFF_CUR1: begin
					r_next.prdata = r_reg.cur[1];
				end
				default: begin
					r_next.pslverr = 1'b1;
				end
			endcase
		end

		// channel engine
		case (r_reg.chan)
			mdc_pkg::MDC_IDLE: begin
				if (r_reg.enable) begin
					r_next.chan = mdc_pkg::MDC_STALL;
					r_next.act = ~r_reg.armed[0] & r_reg.armed[1];
				end
			end
			mdc_pkg::MDC_STALL: begin
				if (!r_reg.enable) begin
					r_next.chan = mdc_pkg::MDC_IDLE;
				end else if (!r_reg.armed[r_reg.act] && r_reg.armed[~r_reg.act]) begin
					r_next.act = ~r_reg.act;
				end else if (trigger && r_reg.armed[r_reg.act] &&
					r_reg.count[r_reg.act] != '0) begin
					r_next.chan = mdc_pkg::MDC_MEM_RD;
					r_next.start_pend = 1'b0;
					r_next.rd_req = 1'b1;
					r_next.rd_addr = r_reg.cur[r_reg.act];
				end
			end
			mdc_pkg::MDC_MEM_RD: begin
				if (i_rd_ack) begin
					r_next.rd_req = 1'b0;
					r_next.wr_data = i_rd_data;
					r_next.wr_req = 1'b1;
					r_next.chan = mdc_pkg::MDC_MEM_WR;
				end
			end
			mdc_pkg::MDC_MEM_WR: begin
				if (i_wr_ack) begin
					r_next.wr_req = 1'b0;
					r_next.count[r_reg.act] = left_after;
					r_next.cur[r_reg.act] = r_reg.cur[r_reg.act] +
						{{(32-COUNT_W){1'b0}}, step};
					if (left_after == '0) begin
						r_next.armed[r_reg.act] = 1'b0;
						irq_set[mdc_pkg::IRQ_DONE_BIT] = 1'b1;
						if (r_reg.armed[~r_reg.act] && r_reg.count[~r_reg.act] != '0) begin
							r_next.act = ~r_reg.act;
							irq_set[mdc_pkg::IRQ_NFB_BIT] = 1'b1;
							r_next.chan = mdc_pkg::MDC_MEM_RD;
							r_next.rd_req = 1'b1;
							r_next.rd_addr = r_reg.cur[~r_reg.act];
						end else begin
							r_next.chan = mdc_pkg::MDC_STALL;
							irq_set[mdc_pkg::IRQ_STALL_BIT] = 1'b1;
						end
					end else begin
						r_next.chan = mdc_pkg::MDC_MEM_RD;
						r_next.rd_req = 1'b1;
						r_next.rd_addr = r_reg.cur[r_reg.act] + {{(32-COUNT_W){1'b0}}, step};
					end
				end
			end
			default: begin
				r_next.chan = mdc_pkg::MDC_IDLE;
				r_next.rd_req = 1'b0;
				r_next.wr_req = 1'b0;
			end
		endcase

		// apb writes in the access cycle; the other descriptor is free to change
		if (wr_acc) begin
			case (i_paddr)
				mdc_pkg::OFF_CTRL: begin
					r_next.enable = i_pwdata[mdc_pkg::CTRL_ENABLE_BIT];
					r_next.pw = i_pwdata[mdc_pkg::CTRL_PW_LSB+:2];
					if (i_pwdata[mdc_pkg::CTRL_START_BIT]) begin
						r_next.start_pend = 1'b1;
					end
				end
				mdc_pkg::OFF_IRQ_STAT: begin
					irq_clr = i_pwdata[mdc_pkg::IRQ_W-1:0];
				end
				mdc_pkg::OFF_IRQ_MASK: begin
					r_next.mask = i_pwdata[mdc_pkg::IRQ_W-1:0];
				end
				mdc_pkg::OFF_COUNT0: begin
					r_next.count[0] = i_pwdata[COUNT_W-1:0];
					r_next.armed[0] = 1'b1;
					r_next.cur[0] = r_reg.src[0];
				end
				mdc_pkg::OFF_COUNT1: begin
					r_next.count[1] = i_pwdata[COUNT_W-1:0];
					r_next.armed[1] = 1'b1;
					r_next.cur[1] = r_reg.src[1];
				end
				mdc_pkg::OFF_SRC0: begin
					r_next.src[0] = i_pwdata;
				end
				mdc_pkg::OFF_SRC1: begin
					r_next.src[1] = i_pwdata;
				end
				default: begin
				end
			endcase
		end

		// buffer state follows the armed descriptors
		case (r_next.armed)
			2'h0: r_next.bufs = mdc_pkg::MDC_NO_BUF;
			2'h3: r_next.bufs = mdc_pkg::MDC_BUF_NEXT;
			default: r_next.bufs = mdc_pkg::MDC_BUF_ON;
		endcase

		// level interrupt from the flags as they will stand
		r_next.irq = |(((irq_flag & ~irq_clr) | irq_set) & r_next.mask);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			r_reg <= '0;
			r_reg.pw <= mdc_pkg::RST_PW;
			r_reg.mask <= mdc_pkg::RST_MASK;
			r_reg.chan <= mdc_pkg::MDC_IDLE;
			r_reg.bufs <= mdc_pkg::MDC_NO_BUF;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_prdata = r_reg.prdata;
	assign o_pready = r_reg.pready;
	assign o_pslverr = r_reg.pslverr;
	assign o_rd_req = r_reg.rd_req;
	assign o_rd_addr = r_reg.rd_addr;
	assign o_rd_size = r_reg.pw;
	assign o_wr_req = r_reg.wr_req;
	assign o_wr_data = r_reg.wr_data;
	assign o_wr_size = r_reg.pw;
	assign o_irq = r_reg.irq;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence src0_write_s;
		wr_acc && i_paddr == mdc_pkg::OFF_SRC0;
	endsequence

	sequence src0_read_s;
		setup && !i_pwrite && i_paddr == mdc_pkg::OFF_SRC0;
	endsequence

	sequence last_beat_s;
		r_reg.chan == mdc_pkg::MDC_MEM_WR && i_wr_ack && left_after == '0;
	endsequence

	count_upper_zero_a: assert property (
		setup && (i_paddr == mdc_pkg::OFF_COUNT0 || i_paddr == mdc_pkg::OFF_COUNT1)
		|=> o_pready && o_prdata[31:COUNT_W] == '0)
		else $error("count read shows non-zero upper bits");

	count_decrement_a: assert property (
		r_reg.chan == mdc_pkg::MDC_MEM_WR && i_wr_ack && !wr_acc &&
		r_reg.count[r_reg.act] > step
		|=> r_reg.count[$past(r_reg.act)] == $past(r_reg.count[r_reg.act]) - $past(step))
		else $error("byte count did not drop by one beat");

	count_write_arm_a: assert property (
		wr_acc && i_paddr == mdc_pkg::OFF_COUNT1
		|=> r_reg.armed[1] && r_reg.cur[1] == $past(r_reg.src[1]) &&
		r_reg.count[1] == $past(i_pwdata[COUNT_W-1:0]))
		else $error("count write did not arm descriptor");

	nfb_on_switch_a: assert property (
		last_beat_s ##0 (r_reg.armed[~r_reg.act] && r_reg.count[~r_reg.act] != '0)
		|=> irq_flag[mdc_pkg::IRQ_NFB_BIT] && r_reg.act != $past(r_reg.act) &&
		o_rd_req ##1 r_reg.chan == mdc_pkg::MDC_MEM_RD)
		else $error("buffer handover missing");

	busy_reprogram_a: assert property (
		(r_reg.chan == mdc_pkg::MDC_MEM_RD) && !i_rd_ack && wr_acc &&
		i_paddr == (r_reg.act ? mdc_pkg::OFF_COUNT0 : mdc_pkg::OFF_COUNT1)
		|=> $stable(r_reg.chan) && $stable(r_reg.rd_addr) &&
		r_reg.count[r_reg.act] == $past(r_reg.count[r_reg.act]))
		else $error("reprogramming disturbed running transfer");

	zero_count_stall_a: assert property (
		r_reg.chan == mdc_pkg::MDC_STALL && r_reg.enable && trigger &&
		r_reg.count[0] == '0 && r_reg.count[1] == '0
		|=> r_reg.chan == mdc_pkg::MDC_STALL && !o_rd_req)
		else $error("transfer started with zero count");

	fetch_from_pointer_a: assert property (
		$rose(o_rd_req) && $past(r_reg.chan) == mdc_pkg::MDC_STALL
		|-> o_rd_addr == r_reg.cur[r_reg.act])
		else $error("fetch address not taken from source pointer");

	src_base_map_a: assert property (
		src0_write_s ##1 src0_read_s |=> o_prdata == $past(i_pwdata, 2))
		else $error("source base readback mismatch");

	irq_level_a: assert property (
		##1 (o_irq == |(irq_flag & r_reg.mask)))
		else $error("interrupt level disagrees with flags");

endmodule
`default_nettype wire

// ===== mdc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_mem_model #(
	parameter logic [31:0] SCRAMBLE = 32'h5a5a_0000
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	// answer delay in cycles
	input wire logic [3:0] i_delay,
	// read side
	input wire logic i_rd_req,
	input wire logic [31:0] i_rd_addr,
	output logic o_rd_ack,
	output logic [31:0] o_rd_data,
	// write side
	input wire logic i_wr_req,
	output logic o_wr_ack
);
	logic [3:0] wait_cnt;

	// one beat at a time after i_delay cycles; data bus churns outside an answer
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wait_cnt <= 4'h0;
			o_rd_ack <= 1'b0;
			o_wr_ack <= 1'b0;
			o_rd_data <= 32'hffff_ffff;
		end else if (o_rd_ack || o_wr_ack) begin
			o_rd_ack <= 1'b0;
			o_wr_ack <= 1'b0;
			wait_cnt <= 4'h0;
			o_rd_data <= ~o_rd_data;
		end else if ((i_rd_req || i_wr_req) && wait_cnt == i_delay) begin
			o_rd_ack <= i_rd_req;
			o_wr_ack <= i_wr_req;
			o_rd_data <= i_rd_req ? (i_rd_addr ^ SCRAMBLE) : ~o_rd_data;
		end else begin
			wait_cnt <= (i_rd_req || i_wr_req) ? wait_cnt + 4'h1 : 4'h0;
			o_rd_data <= ~o_rd_data;
		end
	end
endmodule
`default_nettype wire

// ===== mdc_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_channel_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, preq = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd_addr, rd_data, wr_data, r;
	logic pready, pslverr, rd_req, rd_ack, wr_req, wr_ack, irq, e;
	logic [1:0] rd_size, wr_size;
	logic [3:0] delay = 4'h0;
	logic [31:0] rd_q[$], wr_q[$];
	int fails = 0, comparisons = 0, cycles = 0;
	bit keep_bus = 1'b0, chained = 1'b0;

	always #2.5 clk = ~clk;

	mdc_channel u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_periph_req(preq), .o_rd_req(rd_req),
		.o_rd_addr(rd_addr), .o_rd_size(rd_size), .i_rd_ack(rd_ack), .i_rd_data(rd_data),
		.o_wr_req(wr_req), .o_wr_data(wr_data), .o_wr_size(wr_size), .i_wr_ack(wr_ack),
		.o_irq(irq));
	mdc_mem_model u_mem (.i_ref_clk(clk), .i_nrst(nrst), .i_delay(delay), .i_rd_req(rd_req),
		.i_rd_addr(rd_addr), .o_rd_ack(rd_ack), .o_rd_data(rd_data), .i_wr_req(wr_req),
		.o_wr_ack(wr_ack));

	// ----------------------------------------
	// monitors and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (rd_req && rd_ack) rd_q.push_back(rd_addr);
		if (wr_req && wr_ack) wr_q.push_back(wr_data);
		if (cycles == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		if (!chained) @(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// a chained transfer keeps psel up so its setup follows at once
		chained = keep_bus;
		keep_bus = 1'b0;
		if (!chained) begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0);
		chk(r, exp, msg);
	endtask

	task automatic wait_writes(input int n);
		for (int i = 0; i < 600 && wr_q.size() < n; i++) @(posedge clk);
		chk(wr_q.size(), n, "beat count");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic regs_test();
		rd_chk(mdc_pkg::OFF_SRC0, 32'h0, "src0 reset");
		rd_chk(mdc_pkg::OFF_SRC1, 32'h0, "src1 reset");
		rd_chk(mdc_pkg::OFF_COUNT0, 32'h0, "count0 reset");
		apb(1'b1, mdc_pkg::OFF_SRC1, 32'hffff_ffff);
		rd_chk(mdc_pkg::OFF_SRC1, 32'hffff_ffff, "src1 rw");
		apb(1'b1, mdc_pkg::OFF_SRC1, 32'h0000_2000);
		keep_bus = 1'b1;
		apb(1'b1, mdc_pkg::OFF_SRC0, 32'h0000_1000);
		rd_chk(mdc_pkg::OFF_SRC0, 32'h0000_1000, "src0 back to back");
		apb(1'b1, mdc_pkg::OFF_COUNT0, 32'h0000_0008);
		rd_chk(mdc_pkg::OFF_COUNT0, 32'h0000_0008, "count0 upper zero");
		rd_chk(mdc_pkg::OFF_CUR0, 32'h0000_1000, "pointer copy");
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(r, 32'h0, "unmapped data");
	endtask

	task automatic two_buf_test();
		delay <= 4'hc;
		apb(1'b1, mdc_pkg::OFF_CTRL, 32'h0000_000b);
		apb(1'b1, mdc_pkg::OFF_COUNT1, 32'h0000_0004);
		wait_writes(3);
		chk({30'h0, rd_size}, 32'h2, "read size");
		chk({30'h0, wr_size}, 32'h2, "write size");
		chk(rd_q[0], 32'h0000_1000, "first fetch");
		chk(rd_q[1], 32'h0000_1004, "second fetch");
		chk(rd_q[2], 32'h0000_2000, "handover fetch");
		for (int i = 0; i < 3; i++) chk(wr_q[i], rd_q[i] ^ 32'h5a5a_0000, "write data");
		repeat (4) @(posedge clk);
		rd_chk(mdc_pkg::OFF_COUNT0, 32'h0, "count0 spent");
		rd_chk(mdc_pkg::OFF_CUR0, 32'h0000_1008, "cur0 end");
		rd_chk(mdc_pkg::OFF_CUR1, 32'h0000_2004, "cur1 end");
		rd_chk(mdc_pkg::OFF_IRQ_STAT, 32'h7, "flags");
		apb(1'b1, mdc_pkg::OFF_IRQ_MASK, 32'h2);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1, "irq on");
		apb(1'b1, mdc_pkg::OFF_IRQ_STAT, 32'h2);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rd_chk(mdc_pkg::OFF_IRQ_STAT, 32'h5, "flags left");
	endtask

	task automatic zero_count_test();
		delay <= 4'h0;
		apb(1'b1, mdc_pkg::OFF_COUNT0, 32'h0);
		apb(1'b1, mdc_pkg::OFF_CTRL, 32'h0000_0005);
		preq <= 1'b1;
		repeat (30) @(posedge clk);
		chk(rd_q.size(), 3, "no fetch at zero");
		apb(1'b0, mdc_pkg::OFF_CHAN_STAT, 32'h0);
		chk({28'h0, r[3:0]}, 32'h2, "held in stall");
		apb(1'b1, mdc_pkg::OFF_COUNT0, 32'h0000_0004);
		wait_writes(5);
		chk(rd_q[3], 32'h0000_1000, "reuse base");
		chk(rd_q[4], 32'h0000_1002, "half step fetch");
		chk({30'h0, rd_size}, 32'h1, "half read size");
		chk({30'h0, wr_size}, 32'h1, "half write size");
		preq <= 1'b0;
		rd_chk(mdc_pkg::OFF_CUR0, 32'h0000_1004, "cur0 half end");
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		regs_test();
		two_buf_test();
		zero_count_test();
		tally_and_finish();
	end
endmodule
`default_nettype wire
